/* File: iptu_top.sv */
// io port and interval timer unit: two 8-bit ports, handshake,
// edge flag input and two 16-bit interval timers
// assumes a synchronous processor strobe and pins sampled on clk
`timescale 1ns/1ps
`include "iptu_map.svh"

// Functional notes
// - four select lines pick one of sixteen offsets, ten of them byte registers
// - direction bit one drives the port pin, zero leaves it input
// - port data reads return the pin levels in any direction
// - handshake strobe goes low on third cycle after port b access
// - each falling edge on the edge input sets the edge flag
// - writes go to the timer latch, reads return the counter
// - control bit 0 starts or stops the timer at any write
// - control bit 1 puts timer output on port b bit 6 or 7
// - control bit 2 picks toggle or one-cycle pulse per underflow
// - toggle output goes high on start and low on reset
// - one-shot mode counts down, flags, reloads and stops
// - continuous mode counts down, flags, reloads and repeats
// - one-shot high byte write loads counter and starts timer
// - force-load strobe copies latch to counter at once
// - timer a bit 5 picks system clock or count pin pulses
// - timer b bits 6:5 pick one of four decrement sources
// - reload on underflow, force load, or high write when stopped or in one-shot mode
// - high byte write while running in continuous mode only updates the latch
// - underflow is a decrement past zero and drives all effects
module iptu_top
	import iptu_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic [3:0] reg_select,
	input wire logic bus_cs,
	input wire logic bus_we,
	input wire logic [7:0] bus_wdata,
	output logic [7:0] bus_rdata,
	input wire logic [7:0] port_a_in,
	output logic [7:0] port_a_out,
	output logic [7:0] port_a_oe,
	input wire logic [7:0] port_b_in,
	output logic [7:0] port_b_out,
	output logic [7:0] port_b_oe,
	output logic handshake_strobe_out_n,
	input wire logic edge_detect_n,
	output logic edge_flag,
	input wire logic edge_flag_clear,
	input wire logic external_count_pin,
	output logic timer_a_underflow,
	output logic timer_b_underflow
);

	////////////////////////////////////////////////////////////////////

	function automatic logic hit(input logic [3:0] sel,
		input logic [3:0] off);
		hit = (sel == off);
	endfunction

	function automatic logic [7:0] port_mix(input logic [7:0] base,
		input logic en_a, input logic lvl_a,
		input logic en_b, input logic lvl_b);
		logic [7:0] v;
		v = base;
		if (en_a)
			v[`IPTU_BIT_TA_PIN] = lvl_a;
		if (en_b)
			v[`IPTU_BIT_TB_PIN] = lvl_b;
		port_mix = v;
	endfunction

	////////////////////////////////////////////////////////////////////

	logic wr;
	logic rd;
	logic pb_access;
	logic [7:0] pa_data_r;
	logic [7:0] pb_data_r;
	logic [7:0] pa_dir_r;
	logic [7:0] pb_dir_r;
	logic [7:0] port_b_out_r;
	logic [7:0] port_b_oe_r;
	logic [7:0] rdata_r;
	logic [7:0] rdata_nxt;
	logic [`IPTU_HS_STAGES-1:0] hs_pipe_r;
	logic hs_n_r;
	logic edge_prev_r;
	logic edge_flag_r;
	logic edge_fall;
	logic cnt_prev_r;
	logic cnt_rise;
	logic tick_a;
	logic tick_b;
	logic [15:0] count_a;
	logic [15:0] count_b;
	logic [7:0] ctrl_a;
	logic [7:0] ctrl_b;
	logic uf_a;
	logic uf_b;
	logic lvl_a;
	logic lvl_b;
	iptu_asrc_t src_a;
	iptu_bsrc_t src_b;

	assign wr = bus_cs && bus_we;
	assign rd = bus_cs && !bus_we;
	assign pb_access = bus_cs && hit(reg_select, `IPTU_OFF_PB_DATA);

	////////////////////////////////////////////////////////////////////
	// port data and direction registers

	always_ff @(posedge clk or negedge resetn)
		if (!resetn)
		begin
			pa_data_r <= `IPTU_RST_BYTE;
			pb_data_r <= `IPTU_RST_BYTE;
			pa_dir_r <= `IPTU_RST_BYTE;
			pb_dir_r <= `IPTU_RST_BYTE;
		end
		else if (wr)
		begin
			if (hit(reg_select, `IPTU_OFF_PA_DATA))
				pa_data_r <= bus_wdata;
			if (hit(reg_select, `IPTU_OFF_PB_DATA))
				pb_data_r <= bus_wdata;
			if (hit(reg_select, `IPTU_OFF_PA_DIR))
				pa_dir_r <= bus_wdata;
			if (hit(reg_select, `IPTU_OFF_PB_DIR))
				pb_dir_r <= bus_wdata;
		end

	always_ff @(posedge clk or negedge resetn)
		if (!resetn)
		begin
			port_b_out_r <= `IPTU_RST_BYTE;
			port_b_oe_r <= `IPTU_RST_BYTE;
		end
		else
		begin
			port_b_out_r <= port_mix(pb_data_r,
				ctrl_a[`IPTU_BIT_PORTOUT], lvl_a,
				ctrl_b[`IPTU_BIT_PORTOUT], lvl_b);
			port_b_oe_r <= port_mix(pb_dir_r,
				ctrl_a[`IPTU_BIT_PORTOUT], 1'b1,
				ctrl_b[`IPTU_BIT_PORTOUT], 1'b1);
		end

	// direction bit drives the output enable
	assign port_a_out = pa_data_r;
	assign port_a_oe = pa_dir_r;
	assign port_b_out = port_b_out_r;
	assign port_b_oe = port_b_oe_r;

	////////////////////////////////////////////////////////////////////
	// register read path

	// sixteen-way decode; unused offsets read zero
	always_comb
	begin
		rdata_nxt = `IPTU_RST_BYTE;
		unique case (reg_select)
			`IPTU_OFF_PA_DATA: rdata_nxt = port_a_in;
			`IPTU_OFF_PB_DATA: rdata_nxt = port_b_in;
			`IPTU_OFF_PA_DIR: rdata_nxt = pa_dir_r;
			`IPTU_OFF_PB_DIR: rdata_nxt = pb_dir_r;
			`IPTU_OFF_TA_LO: rdata_nxt = count_a[7:0];
			`IPTU_OFF_TA_HI: rdata_nxt = count_a[15:8];
			`IPTU_OFF_TB_LO: rdata_nxt = count_b[7:0];
			`IPTU_OFF_TB_HI: rdata_nxt = count_b[15:8];
			`IPTU_OFF_TA_CTRL: rdata_nxt = ctrl_a;
			`IPTU_OFF_TB_CTRL: rdata_nxt = ctrl_b;
			default: rdata_nxt = `IPTU_RST_BYTE;
		endcase
	end

	always_ff @(posedge clk or negedge resetn)
		if (!resetn)
			rdata_r <= `IPTU_RST_BYTE;
		else if (rd)
			rdata_r <= rdata_nxt;

	assign bus_rdata = rdata_r;

	////////////////////////////////////////////////////////////////////
	// port b handshake strobe

	// delay line from the port b access
	always_ff @(posedge clk or negedge resetn)
		if (!resetn)
			hs_pipe_r <= '0;
		else
			hs_pipe_r <= {hs_pipe_r[`IPTU_HS_STAGES-2:0], pb_access};

	// low for one cycle per access
	always_ff @(posedge clk or negedge resetn)
		if (!resetn)
			hs_n_r <= 1'b1;
		else
			hs_n_r <= !hs_pipe_r[`IPTU_HS_STAGES-1];

	assign handshake_strobe_out_n = hs_n_r;

	////////////////////////////////////////////////////////////////////
	// edge flag input and count pin

	assign edge_fall = edge_prev_r && !edge_detect_n;
	assign cnt_rise = external_count_pin && !cnt_prev_r;

	always_ff @(posedge clk or negedge resetn)
		if (!resetn)
		begin
			edge_prev_r <= 1'b1;
			cnt_prev_r <= 1'b0;
		end
		else
		begin
			edge_prev_r <= edge_detect_n;
			cnt_prev_r <= external_count_pin;
		end

	// a new fall wins over a clear
	always_ff @(posedge clk or negedge resetn)
		if (!resetn)
			edge_flag_r <= 1'b0;
		else
			edge_flag_r <= edge_fall || (edge_flag_r && !edge_flag_clear);

	assign edge_flag = edge_flag_r;

	////////////////////////////////////////////////////////////////////
	// timer clock sources

	assign src_a = iptu_asrc_t'(ctrl_a[`IPTU_BIT_SRC_LO]);
	assign src_b = iptu_bsrc_t'(ctrl_b[`IPTU_BIT_SRC_HI:`IPTU_BIT_SRC_LO]);

	always_comb
	begin
		tick_a = 1'b1;
		unique case (src_a)
			IPTU_ASRC_PHI2: tick_a = 1'b1;
			IPTU_ASRC_PIN: tick_a = cnt_rise;
		endcase
	end

	always_comb
	begin
		tick_b = 1'b1;
		unique case (src_b)
			IPTU_SRC_PHI2: tick_b = 1'b1;
			IPTU_SRC_PIN: tick_b = cnt_rise;
			IPTU_SRC_TA: tick_b = uf_a;
			IPTU_SRC_TA_GATED: tick_b = uf_a && external_count_pin;
		endcase
	end

	////////////////////////////////////////////////////////////////////
	// the two timers

	// start bit written through the control write
	iptu_timer u_timer_a (
		.clk(clk),
		.resetn(resetn),
		.tick(tick_a),
		.wr_lo(wr && hit(reg_select, `IPTU_OFF_TA_LO)),
		.wr_hi(wr && hit(reg_select, `IPTU_OFF_TA_HI)),
		.wr_ctrl(wr && hit(reg_select, `IPTU_OFF_TA_CTRL)),
		.wdata(bus_wdata),
		.count(count_a),
		.ctrl(ctrl_a),
		.uf(uf_a),
		.port_level(lvl_a)
	);

	iptu_timer u_timer_b (
		.clk(clk),
		.resetn(resetn),
		.tick(tick_b),
		.wr_lo(wr && hit(reg_select, `IPTU_OFF_TB_LO)),
		.wr_hi(wr && hit(reg_select, `IPTU_OFF_TB_HI)),
		.wr_ctrl(wr && hit(reg_select, `IPTU_OFF_TB_CTRL)),
		.wdata(bus_wdata),
		.count(count_b),
		.ctrl(ctrl_b),
		.uf(uf_b),
		.port_level(lvl_b)
	);

	assign timer_a_underflow = uf_a;
	assign timer_b_underflow = uf_b;

	////////////////////////////////////////////////////////////////////
	// checks

	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);

	sequence s_pb_lone;
		pb_access ##1 !pb_access;
	endsequence

	sequence s_hs_low_then_high;
		!handshake_strobe_out_n ##1 handshake_strobe_out_n;
	endsequence

	chk_hs_low_third: assert property (
		pb_access |-> ##3 !handshake_strobe_out_n)
		else $error("handshake strobe not low on third cycle");

	chk_hs_single: assert property (
		s_pb_lone |-> ##2 s_hs_low_then_high)
		else $error("handshake strobe not a single cycle");

	chk_flag_fall: assert property (
		$fell(edge_detect_n) |=> edge_flag)
		else $error("falling edge did not set the flag");

	chk_port_force: assert property (
		ctrl_a[`IPTU_BIT_PORTOUT] |=> port_b_oe[`IPTU_BIT_TA_PIN] &&
		port_b_out[`IPTU_BIT_TA_PIN] == $past(lvl_a))
		else $error("timer a output not on port b");

	chk_dir_follow: assert property (
		wr && hit(reg_select, `IPTU_OFF_PB_DIR) |=> ##1
		port_b_oe[5:0] == $past(bus_wdata[5:0], 2))
		else $error("port b enable does not follow direction");

	chk_read_pins: assert property (
		rd && hit(reg_select, `IPTU_OFF_PA_DATA) |=>
		bus_rdata == $past(port_a_in))
		else $error("port a read is not the pin level");

	chk_timer_read: assert property (
		rd && hit(reg_select, `IPTU_OFF_TB_HI) |=>
		bus_rdata == $past(count_b[15:8]))
		else $error("timer read is not the counter");

	chk_start_stop: assert property (
		wr && hit(reg_select, `IPTU_OFF_TA_CTRL) |=>
		ctrl_a[`IPTU_BIT_START] == $past(bus_wdata[`IPTU_BIT_START]))
		else $error("start bit not taken from the write");

	chk_gated_hold: assert property (
		(ctrl_b[`IPTU_BIT_START] && src_b == IPTU_SRC_TA_GATED &&
		!external_count_pin && !wr) |=> count_b == $past(count_b))
		else $error("gated timer b counted with pin low");

	chk_src_a_pin: assert property (
		(ctrl_a[`IPTU_BIT_START] && src_a == IPTU_ASRC_PIN &&
		!cnt_rise && !wr) |=> count_a == $past(count_a))
		else $error("timer a counted without a pin pulse");

endmodule

/* File: iptu_map.svh */
// register offsets, control bit positions, reset values and counts
// assumes inclusion by the top and timer modules and by the bench
`ifndef IPTU_MAP_SVH
`define IPTU_MAP_SVH

`define IPTU_OFF_PA_DATA 4'h0
`define IPTU_OFF_PB_DATA 4'h1
`define IPTU_OFF_PA_DIR 4'h2
`define IPTU_OFF_PB_DIR 4'h3
`define IPTU_OFF_TA_LO 4'h4
`define IPTU_OFF_TA_HI 4'h5
`define IPTU_OFF_TB_LO 4'h6
`define IPTU_OFF_TB_HI 4'h7
`define IPTU_OFF_TA_CTRL 4'he
`define IPTU_OFF_TB_CTRL 4'hf

`define IPTU_RST_BYTE 8'h00
`define IPTU_RST_WORD 16'h0000

`define IPTU_BIT_START 0
`define IPTU_BIT_PORTOUT 1
`define IPTU_BIT_TOGGLE 2
`define IPTU_BIT_ONESHOT 3
`define IPTU_BIT_FLOAD 4
`define IPTU_BIT_SRC_LO 5
`define IPTU_BIT_SRC_HI 6
`define IPTU_BIT_TA_PIN 6
`define IPTU_BIT_TB_PIN 7

// force-load is a strobe and is never stored
`define IPTU_CTRL_WMASK 8'hef
// handshake delay stages; the strobe goes low one cycle after these, on the third cycle after a port b access
`define IPTU_HS_STAGES 2

`endif

/* File: iptu_pkg.sv */
// types shared by the io port and interval timer unit
// assumes iptu_map.svh for numeric constants
package iptu_pkg;
	typedef enum logic [1:0]
	{
		IPTU_SRC_PHI2 = 2'b00,
		IPTU_SRC_PIN = 2'b01,
		IPTU_SRC_TA = 2'b10,
		IPTU_SRC_TA_GATED = 2'b11
	} iptu_bsrc_t;
	typedef enum logic
	{
		IPTU_ASRC_PHI2 = 1'b0,
		IPTU_ASRC_PIN = 1'b1
	} iptu_asrc_t;
endpackage

/* File: iptu_timer.sv */
// one 16-bit interval timer: latch, down-counter, control, port output
// assumes tick is a one-cycle decrement enable from the parent
`timescale 1ns/1ps
`include "iptu_map.svh"

module iptu_timer
	import iptu_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic tick,
	input wire logic wr_lo,
	input wire logic wr_hi,
	input wire logic wr_ctrl,
	input wire logic [7:0] wdata,
	output logic [15:0] count,
	output logic [7:0] ctrl,
	output logic uf,
	output logic port_level
);
	logic [15:0] latch_r;
	logic [15:0] count_r;
	logic [15:0] latch_nxt;
	logic [7:0] ctrl_r;
	logic tog_r;
	logic pulse_r;
	logic uf_r;
	logic running;
	logic oneshot;
	logic uf_now;
	logic hi_os;
	logic start_rise;
	logic load;

	assign running = ctrl_r[`IPTU_BIT_START];
	assign oneshot = ctrl_r[`IPTU_BIT_ONESHOT];
	assign latch_nxt = {wr_hi ? wdata : latch_r[15:8],
		wr_lo ? wdata : latch_r[7:0]};
	// underflow: decrement requested while the counter holds zero
	assign uf_now = running && tick && (count_r == 16'h0000);
	assign hi_os = wr_hi && oneshot;
	assign start_rise = !running &&
		((wr_ctrl && wdata[`IPTU_BIT_START]) || hi_os);
	assign load = uf_now || (wr_ctrl && wdata[`IPTU_BIT_FLOAD]) ||
		(wr_hi && (!running || oneshot));

	always_ff @(posedge clk or negedge resetn)
		if (!resetn)
			latch_r <= `IPTU_RST_WORD;
		else
			latch_r <= latch_nxt;

	always_ff @(posedge clk or negedge resetn)
		if (!resetn)
			count_r <= `IPTU_RST_WORD;
		else if (load)
			count_r <= latch_nxt;
		else if (running && tick)
			count_r <= count_r - 16'h0001;

	always_ff @(posedge clk or negedge resetn)
		if (!resetn)
			ctrl_r <= `IPTU_RST_BYTE;
		else if (wr_ctrl)
			ctrl_r <= wdata & `IPTU_CTRL_WMASK;
		else if (hi_os)
			ctrl_r[`IPTU_BIT_START] <= 1'b1;
		else if (uf_now && oneshot)
			ctrl_r[`IPTU_BIT_START] <= 1'b0;

	// toggle set on start, cleared by reset
	always_ff @(posedge clk or negedge resetn)
		if (!resetn)
			tog_r <= 1'b0;
		else if (start_rise)
			tog_r <= 1'b1;
		else if (uf_now)
			tog_r <= !tog_r;

	always_ff @(posedge clk or negedge resetn)
		if (!resetn)
		begin
			pulse_r <= 1'b0;
			uf_r <= 1'b0;
		end
		else
		begin
			pulse_r <= uf_now;
			uf_r <= uf_now;
		end

	assign count = count_r;
	assign ctrl = ctrl_r;
	assign uf = uf_r;
	assign port_level = ctrl_r[`IPTU_BIT_TOGGLE] ? tog_r : pulse_r;

	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	chk_uf_reload: assert property (uf_now |=> count_r == $past(latch_nxt))
		else $error("no reload on underflow");
	chk_os_stop: assert property (
		(uf_now && oneshot && !wr_ctrl && !wr_hi) |=> !running)
		else $error("one-shot timer kept running");
	chk_cont_run: assert property (
		(uf_now && !oneshot && !wr_ctrl) |=> running && uf_r)
		else $error("continuous timer stopped");
	chk_fload_now: assert property (
		(wr_ctrl && wdata[`IPTU_BIT_FLOAD]) |=>
		count_r == $past(latch_nxt))
		else $error("force load missed");
	chk_hi_running: assert property (
		(wr_hi && running && !oneshot && !wr_ctrl && !uf_now) |=>
		count_r == $past(count_r) - {15'h0000, $past(tick)})
		else $error("running counter disturbed");
	chk_os_hi_start: assert property (
		(hi_os && !wr_ctrl) |=> running && count_r == $past(latch_nxt))
		else $error("one-shot high write did not start");
	chk_tog_start: assert property (start_rise |=> tog_r)
		else $error("toggle not high on start");
endmodule

/* File: iptu_periph_model.sv */
// peripherals on the port pins, the count pin and the edge input
// assumes pins are resolved here and fed back to the unit's inputs
`timescale 1ns/1ps

module iptu_periph_model
(
	input wire logic clk,
	input wire logic [7:0] port_a_out,
	input wire logic [7:0] port_a_oe,
	input wire logic [7:0] port_b_out,
	input wire logic [7:0] port_b_oe,
	input wire logic handshake_strobe_out_n,
	input wire logic [7:0] drv_a,
	input wire logic [7:0] drv_a_en,
	input wire logic [7:0] drv_b,
	input wire logic [7:0] drv_b_en,
	input wire logic [1:0] pin_mode,
	output logic [7:0] port_a_in,
	output logic [7:0] port_b_in,
	output logic edge_detect_n,
	output logic external_count_pin
);
	logic cnt_q = 1'b0;

	////////////////////////////////////////////////////////////////////
	// pin levels resolved
	// undriven pins float up through the pull-ups
	assign port_a_in = (port_a_oe & port_a_out) |
		(~port_a_oe & drv_a_en & drv_a) | (~port_a_oe & ~drv_a_en);
	assign port_b_in = (port_b_oe & port_b_out) |
		(~port_b_oe & drv_b_en & drv_b) | (~port_b_oe & ~drv_b_en);

	////////////////////////////////////////////////////////////////////
	// handshake loopback
	assign edge_detect_n = handshake_strobe_out_n;

	////////////////////////////////////////////////////////////////////
	// count pin source
	// mode 0 low, 1 high, 2 toggles giving a rise every second cycle
	always @(posedge clk)
	begin
		case (pin_mode)
			2'd0: cnt_q <= 1'b0;
			2'd1: cnt_q <= 1'b1;
			default: cnt_q <= ~cnt_q;
		endcase
	end
	assign external_count_pin = cnt_q;
endmodule

/* File: iptu_top_bench.sv */
// self-checking bench for the io port and interval timer unit
// assumes iptu_map.svh offsets and the peripheral model
`timescale 1ns/1ps
`include "iptu_map.svh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin \
	miscompares++; $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); \
	end end

module iptu_top_bench;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic [3:0] reg_select = 4'h0;
	logic bus_cs = 1'b0;
	logic bus_we = 1'b0;
	logic [7:0] bus_wdata = 8'h00;
	logic edge_flag_clear = 1'b0;
	logic [7:0] drv_a = 8'h00;
	logic [7:0] drv_a_en = 8'h00;
	logic [1:0] pin_mode = 2'd0;
	logic [7:0] bus_rdata, port_a_in, port_a_out, port_a_oe;
	logic [7:0] port_b_in, port_b_out, port_b_oe;
	logic handshake_strobe_out_n, edge_detect_n, edge_flag;
	logic external_count_pin, timer_a_underflow, timer_b_underflow;
	logic [7:0] rv;
	logic [7:0] ca [6] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h21};
	logic [7:0] cb [6] = '{8'h01, 8'h21, 8'h41, 8'h61, 8'h61, 8'h41};
	logic [1:0] pm [6] = '{2'd0, 2'd2, 2'd0, 2'd1, 2'd0, 2'd2};
	int ea [6] = '{40, 40, 40, 40, 40, 20};
	int eb [6] = '{20, 10, 10, 10, 0, 5};
	logic hs_exp [4] = '{1'b1, 1'b1, 1'b0, 1'b1};
	int miscompares = 0;
	int n_checks = 0;
	int ua, ub, p6;

	iptu_top dut_u (.clk(clk), .resetn(resetn), .reg_select(reg_select),
		.bus_cs(bus_cs), .bus_we(bus_we), .bus_wdata(bus_wdata),
		.bus_rdata(bus_rdata), .port_a_in(port_a_in),
		.port_a_out(port_a_out), .port_a_oe(port_a_oe),
		.port_b_in(port_b_in), .port_b_out(port_b_out),
		.port_b_oe(port_b_oe),
		.handshake_strobe_out_n(handshake_strobe_out_n),
		.edge_detect_n(edge_detect_n), .edge_flag(edge_flag),
		.edge_flag_clear(edge_flag_clear),
		.external_count_pin(external_count_pin),
		.timer_a_underflow(timer_a_underflow),
		.timer_b_underflow(timer_b_underflow));

	iptu_periph_model periph_u (.clk(clk), .port_a_out(port_a_out),
		.port_a_oe(port_a_oe), .port_b_out(port_b_out),
		.port_b_oe(port_b_oe),
		.handshake_strobe_out_n(handshake_strobe_out_n),
		.drv_a(drv_a), .drv_a_en(drv_a_en), .drv_b(8'h00),
		.drv_b_en(8'h00), .pin_mode(pin_mode), .port_a_in(port_a_in),
		.port_b_in(port_b_in), .edge_detect_n(edge_detect_n),
		.external_count_pin(external_count_pin));

	initial
	begin
		forever #2.5 clk = ~clk;
	end

	////////////////////////////////////////////////////////////////////
	task complete_run;
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// one access taken at the next edge, strobe dropped an edge later
	task access(input logic [3:0] off, input logic we, input logic [7:0] d);
		reg_select <= off;
		bus_we <= we;
		bus_wdata <= d;
		bus_cs <= 1'b1;
		@(posedge clk);
		bus_cs <= 1'b0;
		@(posedge clk);
	endtask

	task wr(input logic [3:0] off, input logic [7:0] d);
		access(off, 1'b1, d);
	endtask

	task rd(input logic [3:0] off);
		access(off, 1'b0, 8'h00);
		rv = bus_rdata;
	endtask

	// count underflow pulses and port b bit 6 highs over n cycles
	task count(input int n);
		ua = 0;
		ub = 0;
		p6 = 0;
		repeat (n)
		begin
			@(posedge clk);
			ua += (timer_a_underflow === 1'b1);
			ub += (timer_b_underflow === 1'b1);
			p6 += (port_b_out[6] === 1'b1);
		end
	endtask

	////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (20000) @(posedge clk);
		miscompares++;
		complete_run();
	end

	initial
	begin
		repeat (8) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		rd(`IPTU_OFF_PA_DIR);
		`CHK(rv, 8'h00)
		rd(`IPTU_OFF_TB_CTRL);
		`CHK(rv, 8'h00)
		`CHK(handshake_strobe_out_n, 1'b1)
		$display("test reset done");

		drv_a <= 8'h3c;
		drv_a_en <= 8'hff;
		wr(`IPTU_OFF_PA_DIR, 8'h0f);
		wr(`IPTU_OFF_PA_DATA, 8'ha5);
		`CHK(port_a_oe, 8'h0f)
		`CHK(port_a_out, 8'ha5)
		rd(`IPTU_OFF_PA_DATA);
		`CHK(rv, 8'h35)
		rd(4'h9);
		`CHK(rv, 8'h00)
		$display("test ports done");

		wr(`IPTU_OFF_PA_DATA, 8'h5a);
		reg_select <= `IPTU_OFF_PB_DATA;
		bus_we <= 1'b0;
		bus_cs <= 1'b1;
		@(posedge clk);
		bus_cs <= 1'b0;
		for (int i = 0; i < 4; i++)
		begin
			@(posedge clk);
			`CHK(handshake_strobe_out_n, hs_exp[i])
		end
		`CHK(bus_rdata, 8'hff)
		`CHK(edge_flag, 1'b1)
		edge_flag_clear <= 1'b1;
		@(posedge clk);
		edge_flag_clear <= 1'b0;
		repeat (2) @(posedge clk);
		`CHK(edge_flag, 1'b0)
		$display("test handshake done");

		wr(`IPTU_OFF_TA_LO, 8'h04);
		wr(`IPTU_OFF_TA_HI, 8'h00);
		rd(`IPTU_OFF_TA_LO);
		`CHK(rv, 8'h04)
		wr(`IPTU_OFF_PB_DIR, 8'h00);
		wr(`IPTU_OFF_TA_CTRL, 8'h03);
		count(20);
		count(50);
		`CHK(ua, 10)
		`CHK(p6, 10)
		`CHK(port_b_oe[6], 1'b1)
		$display("test continuous done");

		wr(`IPTU_OFF_TA_CTRL, 8'h00);
		wr(`IPTU_OFF_TA_LO, 8'h02);
		wr(`IPTU_OFF_TA_CTRL, 8'h08);
		wr(`IPTU_OFF_TA_HI, 8'h00);
		count(30);
		`CHK(ua, 1)
		rd(`IPTU_OFF_TA_LO);
		`CHK(rv, 8'h02)
		$display("test one-shot done");

		wr(`IPTU_OFF_TA_LO, 8'h00);
		wr(`IPTU_OFF_TA_HI, 8'h01);
		wr(`IPTU_OFF_TA_CTRL, 8'h01);
		wr(`IPTU_OFF_TA_HI, 8'h02);
		rd(`IPTU_OFF_TA_HI);
		`CHK(rv, 8'h00)
		wr(`IPTU_OFF_TA_CTRL, 8'h10);
		rd(`IPTU_OFF_TA_HI);
		`CHK(rv, 8'h02)
		rd(`IPTU_OFF_TA_CTRL);
		`CHK(rv, 8'h00)
		wr(`IPTU_OFF_TA_CTRL, 8'h07);
		repeat (3) @(posedge clk);
		`CHK(port_b_out[6], 1'b1)
		$display("test load and toggle done");

		wr(`IPTU_OFF_TA_CTRL, 8'h00);
		wr(`IPTU_OFF_TA_LO, 8'h01);
		wr(`IPTU_OFF_TA_HI, 8'h00);
		wr(`IPTU_OFF_TB_LO, 8'h03);
		wr(`IPTU_OFF_TB_HI, 8'h00);
		for (int i = 0; i < 6; i++)
		begin
			pin_mode <= pm[i];
			wr(`IPTU_OFF_TA_CTRL, ca[i]);
			wr(`IPTU_OFF_TB_CTRL, cb[i]);
			count(32);
			count(80);
			`CHK(ua, ea[i])
			`CHK(ub, eb[i])
		end
		$display("test sources done");

		wr(`IPTU_OFF_TA_CTRL, 8'h07);
		resetn <= 1'b0;
		repeat (2) @(posedge clk);
		`CHK(port_b_out[6], 1'b0)
		`CHK(port_b_oe, 8'h00)
		resetn <= 1'b1;
		$display("test reset in run done");
		complete_run();
	end
endmodule
